/* inc/pmi_pkg.sv */
// constants for the management interrupt unit
// assumes a 250 MHz mclk and word-per-register access
package pmi_pkg;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS       = 4;
  localparam int NS_PER_MS           = 1000000;
  localparam int ENERGY_DELAY_MS     = 1000;
  localparam int ENERGY_PULSE_MS     = 256;
  localparam int ENERGY_DELAY_CYCLES =
    ENERGY_DELAY_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int ENERGY_PULSE_CYCLES =
    ENERGY_PULSE_MS * (NS_PER_MS / CLK_PERIOD_NS);
  localparam int TIMER_W             = 28;
  // ==========================================================
  // management frame
  localparam logic [5:0] PREAMBLE_BITS = 6'h20;
  localparam logic [1:0] OP_READ       = 2'h2;
  localparam logic [1:0] OP_WRITE      = 2'h1;
  localparam logic [5:0] FIELD_LAST    = 6'h04;
  localparam logic [5:0] DATA_LAST     = 6'h0f;
  // ==========================================================
  // register indices
  localparam logic [4:0] REG_CONTROL    = 5'h00;
  localparam logic [4:0] REG_STATUS     = 5'h01;
  localparam logic [4:0] REG_PARTNER    = 5'h05;
  localparam logic [4:0] REG_EXPANSION  = 5'h06;
  localparam logic [4:0] LAST_STD_REG   = 5'h06;
  localparam logic [4:0] FIRST_VEND_REG = 5'h10;
  localparam logic [4:0] REG_MODE       = 5'h11;
  localparam logic [4:0] REG_IRQ_SOURCE = 5'h1d;
  localparam logic [4:0] REG_IRQ_MASK   = 5'h1e;
  localparam logic [15:0] UNMAPPED_READ = 16'hffff;
  // ==========================================================
  // bit positions
  localparam int BIT_RENEGOTIATE = 9;
  localparam int BIT_NEG_DONE    = 5;
  localparam int BIT_REM_FAULT   = 4;
  localparam int BIT_LINK        = 2;
  localparam int BIT_PARTNER_ACK = 14;
  localparam int BIT_PAR_FAULT   = 4;
  localparam int BIT_PAGE_RX     = 1;
  localparam int BIT_ENERGY      = 1;
  localparam int BIT_ALT_SELECT  = 6;
  localparam int IRQ_LSB         = 1;
  localparam int IRQ_MSB         = 7;
  // source index inside the 7-bit flag vector (register bit - 1)
  localparam int SRC_ENERGY   = 6;
  localparam int SRC_NEG_DONE = 5;
  localparam int SRC_REM_FLT  = 4;
  localparam int SRC_LINKDOWN = 3;
  localparam int SRC_ACK      = 2;
  localparam int SRC_PAR_FLT  = 1;
  localparam int SRC_PAGE     = 0;
  // ==========================================================
  // release groups and reset values
  localparam logic [6:0] REL_ON_FALL  = 7'h77;
  localparam logic [6:0] REL_ON_REG1  = 7'h18;
  localparam logic [6:0] REL_ON_REG6  = 7'h03;
  localparam logic [6:0] REL_ON_RENEG = 7'h03;
  localparam logic [6:0] REL_ALL      = 7'h7f;
  localparam logic [6:0] FLAGS_RESET  = 7'h40;
  localparam logic [6:0] MASK_RESET   = 7'h00;
  localparam logic [6:0] ACT_RESET    = 7'h40;
endpackage : pmi_pkg

/* inc/pmi_frame_if.sv */
// register access strobes from the frame engine to the register file
// assumes both ends run on mclk
`timescale 1ns/1ps
`default_nettype none
interface pmi_frame_if;
  logic        rdStrobe;
  logic        wrStrobe;
  logic [4:0]  regAddr;
  logic [15:0] wrData;
  logic [15:0] rdData;
  modport engine (output rdStrobe, output wrStrobe, output regAddr,
                  output wrData, input rdData);
  modport regfile (input rdStrobe, input wrStrobe, input regAddr,
                   input wrData, output rdData);
endinterface : pmi_frame_if
`default_nettype wire

/* design/pmi_mdio_engine.sv */
// serial management frame engine: decodes read and write frames
// assumes mdc and mdio arrive asynchronously to mclk
`timescale 1ns/1ps
`default_nettype none
module pmi_mdio_engine (
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       mdc,
  input  wire logic       mdioIn,
  output logic            mdioOut,
  output logic            mdioOe,
  input  wire logic [4:0] phyAddress,
  pmi_frame_if.engine     frame
);
  typedef enum {FR_IDLE, FR_START, FR_OP, FR_PHY, FR_REG, FR_TA,
                FR_DATA} pmi_frame_type;
  typedef struct packed {
    pmi_frame_type  state;
    logic [1:0]     mdcSync;
    logic [1:0]     mdioSync;
    logic           mdcPrev;
    logic [5:0]     cnt;
    logic [15:0]    shift;
    logic           isRead;
    logic           oe;
    logic           dout;
    logic           rdStb;
    logic           wrStb;
    logic [4:0]     regAddr;
    logic [15:0]    wrData;
  } pmi_engine_type;

  pmi_engine_type st;
  pmi_engine_type next_st;
  logic           rise;
  logic           bitIn;
  logic [11:0]    header;

  // ==========================================================
  // edge finding on the synchronised management clock
  assign rise   = st.mdcSync[1] & ~st.mdcPrev;
  assign bitIn  = st.mdioSync[1];
  assign header = {st.shift[10:0], bitIn};

  always_comb
  begin
    next_st          = st;
    next_st.mdcSync  = {st.mdcSync[0], mdc};
    next_st.mdioSync = {st.mdioSync[0], mdioIn};
    next_st.mdcPrev  = st.mdcSync[1];
    next_st.rdStb    = 1'b0;
    next_st.wrStb    = 1'b0;
    if (rise)
    begin
      next_st.cnt = st.cnt + 6'h01;
      case (st.state)
        FR_IDLE:
        begin
          if (bitIn)
            next_st.cnt = (st.cnt == pmi_pkg::PREAMBLE_BITS) ?
                          st.cnt : st.cnt + 6'h01;
          else if (st.cnt == pmi_pkg::PREAMBLE_BITS)
            next_st.state = FR_START;
          else
            next_st.cnt = '0;
        end
        FR_START:
        begin
          next_st.cnt   = '0;
          next_st.state = bitIn ? FR_OP : FR_IDLE;
        end
        FR_OP, FR_PHY, FR_REG:
        begin
          next_st.shift = {st.shift[14:0], bitIn};
          if (st.state == FR_OP && st.cnt == 6'h01)
          begin
            next_st.cnt   = '0;
            next_st.state = FR_PHY;
          end
          else if (st.state == FR_PHY && st.cnt == pmi_pkg::FIELD_LAST)
          begin
            next_st.cnt   = '0;
            next_st.state = FR_REG;
          end
          else if (st.state == FR_REG && st.cnt == pmi_pkg::FIELD_LAST)
          begin
            next_st.cnt     = '0;
            next_st.regAddr = header[4:0];
            next_st.isRead  = header[11:10] == pmi_pkg::OP_READ;
            // foreign address or bad opcode: stay silent
            if (header[9:5] != phyAddress ||
                (header[11:10] != pmi_pkg::OP_READ &&
                 header[11:10] != pmi_pkg::OP_WRITE))
              next_st.state = FR_IDLE;
            else
            begin
              next_st.state = FR_TA;
              next_st.rdStb = header[11:10] == pmi_pkg::OP_READ;
            end
          end
        end
        FR_TA:
        begin
          if (st.isRead && st.cnt == 6'h00)
          begin
            next_st.oe   = 1'b1;
            next_st.dout = 1'b0;
          end
          else if (st.cnt == 6'h01)
          begin
            next_st.cnt   = '0;
            next_st.state = FR_DATA;
            next_st.dout  = st.isRead ? frame.rdData[15] : 1'b0;
            next_st.shift = {frame.rdData[14:0], 1'b0};
          end
        end
        FR_DATA:
        begin
          next_st.shift = {st.shift[14:0], bitIn};
          next_st.dout  = st.shift[15];
          if (st.cnt == pmi_pkg::DATA_LAST)
          begin
            next_st.cnt    = '0;
            next_st.state  = FR_IDLE;
            next_st.oe     = 1'b0;
            next_st.wrStb  = ~st.isRead;
            next_st.wrData = {st.shift[14:0], bitIn};
          end
        end
        default:
        begin
          next_st.state = FR_IDLE;
          next_st.cnt   = '0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      st         <= '0;
      st.state   <= FR_IDLE;
      st.mdcSync <= 2'h3;
      st.mdcPrev <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign mdioOut        = st.dout;
  assign mdioOe         = st.oe;
  assign frame.rdStrobe = st.rdStb;
  assign frame.wrStrobe = st.wrStb;
  assign frame.regAddr  = st.regAddr;
  assign frame.wrData   = st.wrData;

  // ==========================================================
  // checks
  property p_drive_only_read;
    @(posedge mclk) disable iff (srst)
    st.oe |-> st.isRead &&
              (st.state == FR_TA || st.state == FR_DATA);
  endproperty
  a_drive_only_read: assert property (p_drive_only_read)
    else $error("data line driven outside a read");
endmodule : pmi_mdio_engine
`default_nettype wire

/* design/pmi_irq_unit.sv */
// management register file and interrupt unit of the transceiver
// assumes status levels come from logic on mclk; mdc/mdio are async
`timescale 1ns/1ps
`default_nettype none
module pmi_irq_unit #(
  parameter int unsigned DELAY_CYCLES = pmi_pkg::ENERGY_DELAY_CYCLES,
  parameter int unsigned PULSE_CYCLES = pmi_pkg::ENERGY_PULSE_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        mdc,
  input  wire logic        mdioIn,
  output logic             mdioOut,
  output logic             mdioOe,
  input  wire logic [4:0]  phyAddress,
  input  wire logic        energy_detected,
  input  wire logic        negotiationDone,
  input  wire logic        remoteFault,
  input  wire logic        linkUp,
  input  wire logic        partnerAck,
  input  wire logic        parallelFault,
  input  wire logic        pageReceived,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq_out_n
);
  typedef enum {EN_IDLE, EN_ARMED, EN_DELAY, EN_PULSE} pmi_energy_type;
  typedef struct packed {
    logic [31:0][15:0]              store;
    logic [6:0]                     flags;
    logic [6:0]                     mask;
    logic [6:0]                     prevAct;
    logic                           altSel;
    pmi_energy_type                 energy;
    logic [pmi_pkg::TIMER_W-1:0]    timer;
    logic [15:0]                    mdioData;
    logic [15:0]                    apbData;
    logic                           apbDone;
    logic                           apbErr;
  } pmi_state_type;

  localparam logic [pmi_pkg::TIMER_W-1:0] DELAY_LAST =
    pmi_pkg::TIMER_W'(DELAY_CYCLES - 1);
  localparam logic [pmi_pkg::TIMER_W-1:0] PULSE_LAST =
    pmi_pkg::TIMER_W'(PULSE_CYCLES - 1);

  pmi_state_type st;
  pmi_state_type next_st;
  pmi_frame_if   frame ();
  logic [6:0]    act;
  logic [6:0]    rise;
  logic [6:0]    fall;
  logic [6:0]    rel;
  logic          mdioAcc;
  logic          apbGo;
  logic          apbErr;
  logic          accRd;
  logic          accWr;
  logic [4:0]    accAddr;
  logic [15:0]   accData;
  logic [15:0]   rdWord;
  logic          pulseOn;

  // ==========================================================
  // frame engine
  pmi_mdio_engine u_engine (
    .mclk       (mclk),
    .srst       (srst),
    .mdc        (mdc),
    .mdioIn     (mdioIn),
    .mdioOut    (mdioOut),
    .mdioOe     (mdioOe),
    .phyAddress (phyAddress),
    .frame      (frame.engine)
  );
  assign frame.rdData = st.mdioData;

  // ==========================================================
  // source levels, active high in flag order
  assign act = {energy_detected, negotiationDone, remoteFault, ~linkUp,
                partnerAck, parallelFault, pageReceived};
  assign rise = act & ~st.prevAct;
  assign fall = ~act & st.prevAct;

  // ==========================================================
  // access arbitration; a frame strobe wins, the bus waits a cycle
  assign mdioAcc = frame.rdStrobe | frame.wrStrobe;
  assign apbErr  = paddr[7] | (paddr[1:0] != 2'h0);
  assign apbGo   = psel & penable & ~st.apbDone & ~mdioAcc;
  assign accRd   = frame.rdStrobe | (apbGo & ~pwrite & ~apbErr);
  assign accWr   = frame.wrStrobe | (apbGo & pwrite & ~apbErr);
  assign accAddr = mdioAcc ? frame.regAddr : paddr[6:2];
  assign accData = mdioAcc ? frame.wrData : pwdata[15:0];

  function automatic logic [15:0] readWord(input logic [4:0]    a,
                                           input pmi_state_type s,
                                           input logic [6:0]    lv);
    logic [15:0] w;
    w = s.store[a];
    case (a)
      pmi_pkg::REG_STATUS:
      begin
        w = '0;
        w[pmi_pkg::BIT_NEG_DONE]  = lv[pmi_pkg::SRC_NEG_DONE];
        w[pmi_pkg::BIT_REM_FAULT] = lv[pmi_pkg::SRC_REM_FLT];
        w[pmi_pkg::BIT_LINK]      = ~lv[pmi_pkg::SRC_LINKDOWN];
      end
      pmi_pkg::REG_PARTNER:
      begin
        w = '0;
        w[pmi_pkg::BIT_PARTNER_ACK] = lv[pmi_pkg::SRC_ACK];
      end
      pmi_pkg::REG_EXPANSION:
      begin
        w = '0;
        w[pmi_pkg::BIT_PAR_FAULT] = lv[pmi_pkg::SRC_PAR_FLT];
        w[pmi_pkg::BIT_PAGE_RX]   = lv[pmi_pkg::SRC_PAGE];
      end
      pmi_pkg::REG_MODE:
      begin
        w[pmi_pkg::BIT_ALT_SELECT] = s.altSel;
        w[pmi_pkg::BIT_ENERGY]     = lv[pmi_pkg::SRC_ENERGY];
      end
      pmi_pkg::REG_IRQ_SOURCE:
      begin
        w = '0;
        w[pmi_pkg::IRQ_MSB:pmi_pkg::IRQ_LSB] = s.flags;
      end
      pmi_pkg::REG_IRQ_MASK:
      begin
        w = '0;
        w[pmi_pkg::IRQ_MSB:pmi_pkg::IRQ_LSB] = s.mask;
      end
      default:
      begin
        if (a > pmi_pkg::LAST_STD_REG && a < pmi_pkg::FIRST_VEND_REG)
          w = pmi_pkg::UNMAPPED_READ;
      end
    endcase
    return w;
  endfunction : readWord

  assign rdWord = readWord(accAddr, st, act);

  // ==========================================================
  // release terms for the current cycle
  always_comb
  begin
    rel = '0;
    if (!st.altSel)
    begin
      rel = fall & pmi_pkg::REL_ON_FALL;
      if (accRd && accAddr == pmi_pkg::REG_IRQ_SOURCE)
        rel = pmi_pkg::REL_ALL;
      if (accRd && accAddr == pmi_pkg::REG_STATUS)
        rel = rel | pmi_pkg::REL_ON_REG1;
      if (accRd && accAddr == pmi_pkg::REG_EXPANSION)
        rel = rel | pmi_pkg::REL_ON_REG6;
      if ((accWr && accAddr == pmi_pkg::REG_CONTROL &&
           accData[pmi_pkg::BIT_RENEGOTIATE]) ||
          rise[pmi_pkg::SRC_LINKDOWN])
        rel = rel | pmi_pkg::REL_ON_RENEG;
    end
    else if (accWr && accAddr == pmi_pkg::REG_IRQ_SOURCE)
      // a flag only drops once its source has gone inactive
      rel = accData[pmi_pkg::IRQ_MSB:pmi_pkg::IRQ_LSB] & ~act;
  end

  // ==========================================================
  // state update
  always_comb
  begin
    next_st         = st;
    next_st.prevAct = act;
    next_st.flags   = (st.flags & ~rel) | rise;
    next_st.apbDone = apbGo;
    if (apbGo)
      next_st.apbErr = apbErr;
    if (apbGo && !pwrite)
      next_st.apbData = apbErr ? 16'h0000 : rdWord;
    if (frame.rdStrobe)
      next_st.mdioData = rdWord;
    if (accWr)
    begin
      case (accAddr)
        pmi_pkg::REG_STATUS, pmi_pkg::REG_PARTNER,
        pmi_pkg::REG_EXPANSION, pmi_pkg::REG_IRQ_SOURCE:
          next_st.store = st.store;
        pmi_pkg::REG_IRQ_MASK:
          next_st.mask = accData[pmi_pkg::IRQ_MSB:pmi_pkg::IRQ_LSB];
        pmi_pkg::REG_MODE:
        begin
          next_st.store[accAddr] = accData;
          next_st.altSel = accData[pmi_pkg::BIT_ALT_SELECT];
        end
        default:
          if (accAddr <= pmi_pkg::LAST_STD_REG ||
              accAddr >= pmi_pkg::FIRST_VEND_REG)
            next_st.store[accAddr] = accData;
      endcase
    end
    // late energy pulse; clearing the mask always cancels it
    next_st.timer = st.timer + 1'b1;
    case (st.energy)
      EN_IDLE:
      begin
        next_st.timer = '0;
        if (st.flags[pmi_pkg::SRC_ENERGY] &&
            !next_st.flags[pmi_pkg::SRC_ENERGY] &&
            act[pmi_pkg::SRC_ENERGY] && st.mask[pmi_pkg::SRC_ENERGY])
          next_st.energy = EN_ARMED;
      end
      EN_ARMED:
      begin
        next_st.timer = '0;
        if (fall[pmi_pkg::SRC_ENERGY])
          next_st.energy = EN_DELAY;
      end
      EN_DELAY:
      begin
        if (rise[pmi_pkg::SRC_ENERGY])
          next_st.energy = EN_ARMED;
        else if (st.timer == DELAY_LAST)
        begin
          next_st.timer  = '0;
          next_st.energy = EN_PULSE;
        end
      end
      EN_PULSE:
        if (st.timer == PULSE_LAST)
          next_st.energy = EN_IDLE;
      default:
        next_st.energy = EN_IDLE;
    endcase
    if (!next_st.mask[pmi_pkg::SRC_ENERGY])
      next_st.energy = EN_IDLE;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      st         <= '0;
      st.flags   <= pmi_pkg::FLAGS_RESET;
      st.mask    <= pmi_pkg::MASK_RESET;
      st.prevAct <= pmi_pkg::ACT_RESET;
      st.altSel  <= 1'b0;
      st.energy  <= EN_IDLE;
    end
    else
      st <= next_st;
  end

  // ==========================================================
  // outputs
  assign pulseOn   = st.energy == EN_PULSE;
  assign irq_out_n = ~(|(st.flags & st.mask) | pulseOn);
  assign prdata    = {16'h0000, st.apbData};
  assign pready    = st.apbDone;
  assign pslverr   = st.apbDone & st.apbErr;

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  property p_unmapped;
    apbGo && !pwrite && !apbErr && paddr[6:2] > pmi_pkg::LAST_STD_REG &&
    paddr[6:2] < pmi_pkg::FIRST_VEND_REG |=> pready && prdata[15:0] ==
    pmi_pkg::UNMAPPED_READ;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped register did not read ffff");

  property p_event_asserts;
    |(act & ~st.prevAct & next_st.mask) |=> !irq_out_n;
  endproperty
  a_event_asserts: assert property (p_event_asserts)
    else $error("unmasked event did not assert interrupt");

  property p_reset_primary;
    $past(srst) |-> !st.altSel && st.flags[pmi_pkg::SRC_ENERGY];
  endproperty
  a_reset_primary: assert property (p_reset_primary)
    else $error("reset did not restore primary mode and energy flag");

  property p_read29_release;
    !st.altSel && accRd && accAddr == pmi_pkg::REG_IRQ_SOURCE &&
    !rise[pmi_pkg::SRC_ACK] |=> !st.flags[pmi_pkg::SRC_ACK];
  endproperty
  a_read29_release: assert property (p_read29_release)
    else $error("flag register read did not release flag");

  property p_read1_release;
    !st.altSel && accRd && accAddr == pmi_pkg::REG_STATUS &&
    !rise[pmi_pkg::SRC_LINKDOWN] |=> !st.flags[pmi_pkg::SRC_LINKDOWN];
  endproperty
  a_read1_release: assert property (p_read1_release)
    else $error("status read did not release link down");

  property p_loss_release;
    !st.altSel && rise[pmi_pkg::SRC_LINKDOWN] && !rise[pmi_pkg::SRC_PAGE]
    |=> !st.flags[pmi_pkg::SRC_PAGE];
  endproperty
  a_loss_release: assert property (p_loss_release)
    else $error("link loss did not release page flag");

  property p_pulse_start;
    st.energy == EN_DELAY && st.timer == DELAY_LAST &&
    !rise[pmi_pkg::SRC_ENERGY] && next_st.mask[pmi_pkg::SRC_ENERGY]
    |=> !irq_out_n;
  endproperty
  a_pulse_start: assert property (p_pulse_start)
    else $error("late energy pulse missing");

  property p_mask_release;
    st.altSel && accWr && accAddr == pmi_pkg::REG_IRQ_MASK &&
    accData[pmi_pkg::IRQ_MSB:pmi_pkg::IRQ_LSB] == 7'h00 |=> irq_out_n;
  endproperty
  a_mask_release: assert property (p_mask_release)
    else $error("clearing masks did not release interrupt");

  property p_hold_active;
    st.altSel && accWr && accAddr == pmi_pkg::REG_IRQ_SOURCE &&
    st.flags[pmi_pkg::SRC_ENERGY] && act[pmi_pkg::SRC_ENERGY]
    |=> st.flags[pmi_pkg::SRC_ENERGY];
  endproperty
  a_hold_active: assert property (p_hold_active)
    else $error("flag cleared while source still active");

  property p_link_cond;
    st.altSel && accWr && accAddr == pmi_pkg::REG_IRQ_SOURCE &&
    accData[pmi_pkg::SRC_LINKDOWN + 1] && linkUp &&
    !rise[pmi_pkg::SRC_LINKDOWN] |=> !st.flags[pmi_pkg::SRC_LINKDOWN];
  endproperty
  a_link_cond: assert property (p_link_cond)
    else $error("link down flag not cleared with link up");
endmodule : pmi_irq_unit
`default_nettype wire

/* dv/pmi_station_model.sv */
// station manager model: sends management frames on mdc and mdio
// assumes the bench resolves the shared data line with a pull-up
`timescale 1ns/1ps
`default_nettype none
module pmi_station_model (
  output logic      mdc,
  output logic      smOe,
  output logic      smOut,
  input  wire logic mdio
);
  // level seen on the second turnaround bit of the last frame
  logic taBit;
  // ==========================================================
  // bit timing
  // mdc stands low between frames
  initial
  begin
    mdc = 1'b0;
    smOe = 1'b0;
    smOut = 1'b1;
  end
  task automatic tick(input logic b, output logic s);
    smOut = b;
    #200;
    s = mdio;
    mdc = 1'b1;
    #200;
    mdc = 1'b0;
  endtask : tick
  // ==========================================================
  // frames
  task automatic xfer(input logic [1:0] op, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] f;
    logic        s;
    f = {2'h1, op, 5'h00, ra, 2'h2, wd};
    smOe = 1'b1;
    repeat (32) tick(1'b1, s);
    for (int i = 31; i >= 0; i--)
    begin
      if (op == 2'h2 && i == 17) smOe = 1'b0;
      tick(f[i], s);
      if (i < 16) rd[i] = s;
      if (i == 16) taBit = s;
    end
    smOe = 1'b0;
  endtask : xfer
endmodule : pmi_station_model
`default_nettype wire

/* dv/pmi_irq_unit_tb_top.sv */
// bench for the management interrupt unit over apb and mdio
// assumes phy address 0 and shortened energy timers
`timescale 1ns/1ps
`default_nettype none
module pmi_irq_unit_tb_top;
  logic mclk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, irqN, mdc, smOe, smOut, mdioOut, mdioOe;
  logic [6:0] src = 7'h48;
  logic [15:0] r;
  logic rerr;
  int n_mismatch = 0, total_checks = 0;
  wire logic mdio = mdioOe ? mdioOut : smOe ? smOut : 1'b1;
  always #2 mclk = ~mclk;
  pmi_irq_unit #(.DELAY_CYCLES(20), .PULSE_CYCLES(8)) dut (
    .mclk(mclk), .srst(srst), .mdc(mdc), .mdioIn(mdio),
    .mdioOut(mdioOut), .mdioOe(mdioOe), .phyAddress(5'h00),
    .energy_detected(src[6]), .negotiationDone(src[5]),
    .remoteFault(src[4]), .linkUp(src[3]), .partnerAck(src[2]),
    .parallelFault(src[1]), .pageReceived(src[0]), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_out_n(irqN));
  pmi_station_model sm (.mdc(mdc), .smOe(smOe), .smOut(smOut),
    .mdio(mdio));
  // ==========================================================
  // helpers
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata[15:0];
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task put(input logic [6:0] v);
    @(posedge mclk);
    src <= v;
    repeat (4) @(posedge mclk);
  endtask : put
  task irq(input logic e);
    repeat (4) @(posedge mclk);
    chk("irq_out_n", {15'h0000, e}, {15'h0000, irqN});
  endtask : irq
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // ==========================================================
  // scenarios
  task t_map;
    apb(0, 8'h44, 0);
    chk("alt_select", 16'h0000, r & 16'h0040);
    chk("energy_status", 16'h0002, r & 16'h0002);
    irq(1);
    apb(0, 8'h74, 0);
    chk("flags_reset", 16'h0080, r);
    apb(0, 8'h20, 0);
    chk("reg8", 16'hffff, r);
    apb(0, 8'h82, 0);
    chk("pslverr", 16'h0001, {15'h0000, rerr});
    chk("err_data", 16'h0000, r);
    sm.xfer(2'h2, 5'h07, 0, r);
    chk("mdio_reg7", 16'hffff, r);
    // pull-up alone would also give ffff: the driven turnaround proves it
    chk("mdio_ta", 16'h0000, {15'h0000, sm.taBit});
    sm.xfer(2'h1, 5'h10, 16'ha5c3, r);
    apb(0, 8'h40, 0);
    chk("reg16", 16'ha5c3, r);
    sm.xfer(2'h2, 5'h10, 0, r);
    chk("mdio_reg16", 16'ha5c3, r);
    $display("test map done");
  endtask : t_map
  task t_primary;
    apb(1, 8'h78, 16'h0010);
    put(7'h00);
    irq(0);
    apb(0, 8'h04, 0);
    irq(1);
    apb(1, 8'h78, 16'h0040);
    put(7'h28);
    irq(0);
    put(7'h08);
    irq(1);
    put(7'h28);
    apb(0, 8'h74, 0);
    chk("flags", 16'h0040, r);
    irq(1);
    apb(1, 8'h78, 16'h0002);
    put(7'h09);
    irq(0);
    apb(1, 8'h00, 16'h0200);
    irq(1);
    $display("test primary done");
  endtask : t_primary
  task t_energy;
    apb(1, 8'h78, 16'h0080);
    put(7'h48);
    irq(0);
    apb(0, 8'h74, 0);
    chk("flags_energy", 16'h0080, r);
    irq(1);
    // released while high: pulse after 20 cycles, 8 cycles long
    put(7'h08);
    irq(1);
    repeat (11) @(posedge mclk);
    irq(0);
    repeat (4) @(posedge mclk);
    irq(1);
    apb(1, 8'h78, 16'h0002);
    $display("test energy done");
  endtask : t_energy
  task t_alt;
    put(7'h48);
    apb(1, 8'h44, 16'h0040);
    put(7'h49);
    irq(0);
    apb(1, 8'h74, 16'h0082);
    irq(0);
    put(7'h48);
    irq(0);
    apb(1, 8'h74, 16'h0092);
    irq(1);
    apb(0, 8'h74, 0);
    chk("flags_alt", 16'h0080, r);
    put(7'h49);
    apb(1, 8'h78, 0);
    irq(1);
    $display("test alt done");
  endtask : t_alt
  initial
  begin
    repeat (3) @(posedge mclk);
    srst <= 0;
    t_map;
    t_primary;
    t_energy;
    t_alt;
    final_report;
  end
  initial
  begin
    #150us;
    n_mismatch++;
    final_report;
  end
endmodule : pmi_irq_unit_tb_top
`default_nettype wire
